/* hw/asp_monitor.sv */
// axis status flags and position registers behind an apb slave
`timescale 1ns/1ps
module asp_monitor
    import asp_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [asp_pkg::AW-1:0] paddr,
    input  wire logic [asp_pkg::DW-1:0] pwdata,
    output logic       [asp_pkg::DW-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  scan_tick,
    input  wire logic [asp_pkg::DW-1:0] scan_delta,
    input  wire logic                  homing_busy,
    input  wire logic                  homing_end,
    input  wire logic                  abs_read_end,
    input  wire logic                  wrap_load_end,
    input  wire logic                  lock_engaged,
    input  wire logic                  enc_reverse,
    output logic       [asp_pkg::DW-1:0] drive_ref_pos,
    output logic                       drive_ref_stb,
    output logic                       irq
);
    import asp_pkg::*;

    //======================================================================
    // software registers
    logic [RC_W-1:0]  run_command_word;
    logic [DW-1:0]    turn_preset_value;
    logic             cfg_infinite;
    logic [DW-1:0]    rotary_max_value;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_stat;

    //======================================================================
    // scan snapshot state
    logic          homing_done_flag;
    logic          motion_inhibit_flag;
    logic          abs_done_flag;
    logic          wrap_info_load_done;
    logic          turn_count_preset_done;
    logic          enc_dir_flag;
    logic [DW-1:0] target_pos;
    logic [DW-1:0] calc_target_pos;
    logic [DW-1:0] reference_out_pos;
    logic [DW-1:0] wide_coord_pos;
    logic [DW-1:0] turn_count;
    logic          homing_pend;
    logic          abs_pend;
    logic          load_pend;

    //======================================================================
    // apb decode
    logic [AW-1:0]    idx;
    logic             setup;
    logic             access;
    logic             wr_go;
    logic             rd_go;
    logic             hit_status;
    logic             hit_target;
    logic             hit_calc;
    logic             hit_ref;
    logic             hit_wide;
    logic             hit_run;
    logic             hit_preset;
    logic             hit_config;
    logic             hit_rstps;
    logic             hit_turns;
    logic             hit_istat;
    logic             hit_imask;
    logic             hit_ro;
    logic             hit_rw;
    logic             bad_access;
    logic [SW-1:0]    status_word;
    logic [DW-1:0]    rd_mux;
    logic [IRQ_W-1:0] rd_clear;

    assign idx        = {2'b00, paddr[AW-1:2]};
    assign setup      = psel && !penable;
    assign access     = psel && penable && pready;
    assign hit_status = (idx == IDX_STATUS);
    assign hit_target = (idx == IDX_TARGET);
    assign hit_calc   = (idx == IDX_CALC);
    assign hit_ref    = (idx == IDX_REF);
    assign hit_wide   = (idx == IDX_WIDE);
    assign hit_turns  = (idx == IDX_TURNS);
    assign hit_istat  = (idx == IDX_IRQ_STAT);
    assign hit_run    = (idx == IDX_RUN_CMD);
    assign hit_preset = (idx == IDX_PRESET);
    assign hit_config = (idx == IDX_CONFIG);
    assign hit_rstps  = (idx == IDX_RESET_PS);
    assign hit_imask  = (idx == IDX_IRQ_MASK);
    assign hit_ro     = hit_status || hit_target || hit_calc || hit_ref
                     || hit_wide || hit_turns || hit_istat;
    assign hit_rw     = hit_run || hit_preset || hit_config || hit_rstps
                     || hit_imask;
    // misaligned, unmapped, or a write to a monitor register
    assign bad_access = (paddr[1:0] != 2'b00) || !(hit_ro || hit_rw)
                     || (pwrite && hit_ro);
    assign wr_go      = access && pwrite && !pslverr;
    assign rd_go      = access && !pwrite && !pslverr;

    assign status_word = SW'({enc_dir_flag,                   // see RULE_07
                              turn_count_preset_done,
                              wrap_info_load_done,
                              abs_done_flag,
                              motion_inhibit_flag,
                              homing_done_flag}) << ST_HOMED;

    assign rd_mux =
        hit_status ? {{(DW-SW){1'b0}}, status_word} :
        hit_target ? target_pos :
        hit_calc   ? calc_target_pos :
        hit_ref    ? reference_out_pos :
        hit_wide   ? wide_coord_pos :
        hit_turns  ? turn_count :
        hit_istat  ? {{(DW-IRQ_W){1'b0}}, irq_stat} :
        hit_run    ? {{(DW-RC_W){1'b0}}, run_command_word} :
        hit_preset ? turn_preset_value :
        hit_config ? {{(DW-1){1'b0}}, cfg_infinite} :
        hit_rstps  ? rotary_max_value :
        hit_imask  ? {{(DW-IRQ_W){1'b0}}, irq_mask} : '0;

    // only bits that were actually returned get cleared
    assign rd_clear = (rd_go && hit_istat) ? prdata[IRQ_W-1:0] : '0;

    // one wait-free access phase; data and error are built in setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && bad_access;
            prdata  <= (setup && !pwrite && !bad_access) ? rd_mux : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_command_word  <= '0;
            turn_preset_value <= '0;
            cfg_infinite      <= 1'b0;
            rotary_max_value  <= RSTPOS_INIT;
            irq_mask          <= '0;
        end
        else if (wr_go)
        begin
            if (hit_run)
                run_command_word <= pwdata[RC_W-1:0];
            if (hit_preset)
                turn_preset_value <= pwdata;
            if (hit_config)
                cfg_infinite <= pwdata[CFG_INFINITE];
            if (hit_rstps)
                rotary_max_value <= pwdata;
            if (hit_imask)
                irq_mask <= pwdata[IRQ_W-1:0];
        end
    end

    //======================================================================
    // per-scan next values
    logic          lock_req;
    logic          abs_req;
    logic          load_req;
    logic          preset_req;
    logic          next_lock;
    logic          next_homed;
    logic          next_abs;
    logic          next_load;
    logic          next_preset;
    logic [DW-1:0] next_calc;
    logic [DW-1:0] next_target;
    logic [DW-1:0] next_wide;
    logic [DW-1:0] next_turns;
    logic          wrap_up;
    logic          wrap_dn;

    assign lock_req   = run_command_word[RC_LOCK];
    assign abs_req    = run_command_word[RC_ABS_REQ];
    assign load_req   = run_command_word[RC_LOAD];
    assign preset_req = run_command_word[RC_PRESET];

    assign next_lock   = lock_req && lock_engaged;              // see RULE_02
    // busy holds the flag low; a finish lands at the next scan
    assign next_homed  = !homing_busy
                      && (homing_done_flag || homing_pend
                          || homing_end);                       // see RULE_01
    assign next_abs    = abs_req
                      && (abs_done_flag || abs_pend
                          || abs_read_end);                     // see RULE_03
    assign next_load   = load_req
                      && (wrap_info_load_done || load_pend
                          || wrap_load_end);                    // see RULE_05
    assign next_preset = preset_req;                            // see RULE_06
    // target keeps counting with no wrap, lock or not
    assign next_target = target_pos + scan_delta;        // see RULE_08 RULE_11
    // free 32-bit roll; on a finite axis this tracks the calculated value
    assign next_wide   = cfg_infinite ? wide_coord_pos + scan_delta
                                      : next_calc;       // see RULE_15 RULE_16
    assign next_turns  = preset_req ? turn_preset_value :
                         wrap_up    ? turn_count + 32'h0000_0001 :
                         wrap_dn    ? turn_count - 32'h0000_0001 :
                                      turn_count;

    asp_wrap #(
        .W         (DW)
    ) u_wrap (
        .cur       (calc_target_pos),
        .delta     (scan_delta),
        .infinite  (cfg_infinite),
        .reset_pos (rotary_max_value),
        .next_pos  (next_calc),
        .wrap_up   (wrap_up),
        .wrap_dn   (wrap_dn)
    );

    //======================================================================
    // completion events between scans are held until the next scan
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            homing_pend <= 1'b0;
            abs_pend    <= 1'b0;
            load_pend   <= 1'b0;
        end
        else
        begin
            homing_pend <= !scan_tick && !homing_busy
                        && (homing_pend || homing_end);
            abs_pend    <= !scan_tick && abs_req && (abs_pend || abs_read_end);
            load_pend   <= !scan_tick && load_req
                        && (load_pend || wrap_load_end);
        end
    end

    // every status flag and position the host reads changes on the same scan edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            homing_done_flag       <= 1'b0;
            motion_inhibit_flag    <= 1'b0;
            abs_done_flag          <= 1'b0;
            wrap_info_load_done    <= 1'b0;
            turn_count_preset_done <= 1'b0;
            enc_dir_flag           <= 1'b0;
            target_pos             <= POS_RESET;                // see RULE_09
            calc_target_pos        <= POS_RESET;
            reference_out_pos      <= POS_RESET;
            wide_coord_pos         <= POS_RESET;
            turn_count             <= POS_RESET;
        end
        else if (scan_tick)                                     // see RULE_17
        begin
            homing_done_flag       <= next_homed;
            motion_inhibit_flag    <= next_lock;
            abs_done_flag          <= next_abs;                 // see RULE_04
            wrap_info_load_done    <= next_load;
            turn_count_preset_done <= next_preset;
            enc_dir_flag           <= enc_reverse;
            target_pos             <= next_target;              // see RULE_10
            calc_target_pos        <= next_calc;
            wide_coord_pos         <= next_wide;
            turn_count             <= next_turns;
            if (!next_lock)
                reference_out_pos <= next_calc;                 // see RULE_14
        end
    end

    // drive reference goes out only for unlocked scans
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive_ref_pos <= POS_RESET;
            drive_ref_stb <= 1'b0;
        end
        else
        begin
            drive_ref_stb <= scan_tick && !next_lock;           // see RULE_13
            if (scan_tick && !next_lock)
                drive_ref_pos <= next_calc;
        end
    end

    //======================================================================
    // interrupts: sticky events, read clears, a new event wins
    logic [IRQ_W-1:0] irq_evt;

    assign irq_evt[IRQ_SCAN]   = scan_tick;
    assign irq_evt[IRQ_HOMED]  = scan_tick && next_homed && !homing_done_flag;
    assign irq_evt[IRQ_ABS]    = scan_tick && next_abs && !abs_done_flag;
    assign irq_evt[IRQ_LOAD]   = scan_tick && next_load && !wrap_info_load_done;
    assign irq_evt[IRQ_PRESET] = scan_tick && next_preset
                              && !turn_count_preset_done;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat <= (irq_stat & ~rd_clear) | irq_evt;
            irq <= |(((irq_stat & ~rd_clear) | irq_evt) & irq_mask);
        end
    end

    //======================================================================
    // checks
    sequence s_unlocked_scan;
        scan_tick && !next_lock;
    endsequence

    sequence s_locked_scan;
        scan_tick && next_lock;
    endsequence

    chk_homing_busy: assert property (                          // see RULE_01
        @(posedge pclk) disable iff (!presetn)
        scan_tick && homing_busy |=> !homing_done_flag)
        else $error("homing flag set while homing busy");

    chk_lock_flag: assert property (                            // see RULE_02
        @(posedge pclk) disable iff (!presetn)
        scan_tick |=> motion_inhibit_flag ==
            ($past(lock_req) && $past(lock_engaged)))
        else $error("lock flag disagrees with command and lock state");

    chk_abs_done: assert property (                             // see RULE_03
        @(posedge pclk) disable iff (!presetn)
        scan_tick && abs_req && abs_pend |=> abs_done_flag)
        else $error("absolute read completion not reported");

    chk_abs_clear: assert property (                            // see RULE_04
        @(posedge pclk) disable iff (!presetn)
        scan_tick && !abs_req |=> !abs_done_flag ##1 (!abs_done_flag
            || $past(scan_tick)))
        else $error("absolute read done not cleared by request drop");

    chk_load_done: assert property (                            // see RULE_05
        @(posedge pclk) disable iff (!presetn)
        scan_tick |=> wrap_info_load_done |-> $past(load_req))
        else $error("load done set without load command");

    chk_preset_load: assert property (                          // see RULE_06
        @(posedge pclk) disable iff (!presetn)
        scan_tick && preset_req |=> turn_count_preset_done
            && turn_count == $past(turn_preset_value))
        else $error("turn preset not loaded or not reported");

    chk_enc_dir: assert property (                              // see RULE_07
        @(posedge pclk) disable iff (!presetn)
        scan_tick |=> status_word[ST_DIR] == $past(enc_reverse))
        else $error("direction bit does not follow encoder");

    chk_target_step: assert property (                   // see RULE_10 RULE_11
        @(posedge pclk) disable iff (!presetn)
        scan_tick |=> target_pos == $past(target_pos) + $past(scan_delta))
        else $error("target position missed a scan step");

    chk_ref_freeze: assert property (                           // see RULE_13
        @(posedge pclk) disable iff (!presetn)
        s_locked_scan |=> $stable(reference_out_pos) && !drive_ref_stb)
        else $error("reference moved or was sent under lock");

    chk_ref_follow: assert property (                           // see RULE_14
        @(posedge pclk) disable iff (!presetn)
        s_unlocked_scan |=> reference_out_pos == calc_target_pos
            && drive_ref_stb && drive_ref_pos == calc_target_pos)
        else $error("reference does not follow calculated position");

    chk_wide_finite: assert property (                          // see RULE_15
        @(posedge pclk) disable iff (!presetn)
        scan_tick && !cfg_infinite |=> wide_coord_pos == calc_target_pos)
        else $error("wide position differs on finite axis");

    chk_hold_between: assert property (                         // see RULE_17
        @(posedge pclk) disable iff (!presetn)
        !scan_tick |=> $stable(target_pos) && $stable(status_word))
        else $error("snapshot changed between scans");

endmodule

/* hw/asp_pkg.sv */
// axis status and position monitor: constants, register map, field layout
//==========================================================================
// Functional notes
// (RULE_01) homing flag set on completion, cleared while busy
// (RULE_02) lock flag needs command bit and actual lock
// (RULE_03) absolute read done set after request completes
// (RULE_04) dropping the request clears absolute read done
// (RULE_05) wrap info load done needs load bit
// (RULE_06) turn preset done when counter loaded from preset
// (RULE_07) encoder direction bit: 0 forward, 1 reverse
// (RULE_08) target position is per-scan machine target
// (RULE_09) reset clears target, calculated and reference positions
// (RULE_10) target and calculated positions update under lock
// (RULE_11) target position never wraps on infinite axis
// (RULE_12) infinite axis calculated position wraps to range
// (RULE_13) lock freezes reference position, no drive output
// (RULE_14) reference position follows calculated without lock
// (RULE_15) finite axis wide position equals calculated position
// (RULE_16) wide position wraps naturally over 32 bits
// (RULE_17) all flags and positions commit once per scan
package asp_pkg;

    localparam int DW      = 32;
    localparam int AW      = 12;
    localparam int SW      = 16;
    localparam int IRQ_W   = 5;

    // register indices as printed; byte address is four times the index
    localparam logic [AW-1:0] IDX_STATUS   = 12'h00c;
    localparam logic [AW-1:0] IDX_TARGET   = 12'h00e;
    localparam logic [AW-1:0] IDX_CALC     = 12'h010;
    localparam logic [AW-1:0] IDX_REF      = 12'h012;
    localparam logic [AW-1:0] IDX_WIDE     = 12'h014;
    localparam logic [AW-1:0] IDX_RUN_CMD  = 12'h000;
    localparam logic [AW-1:0] IDX_PRESET   = 12'h04c;
    localparam logic [AW-1:0] IDX_CONFIG   = 12'h001;
    localparam logic [AW-1:0] IDX_RESET_PS = 12'h002;
    localparam logic [AW-1:0] IDX_TURNS    = 12'h003;
    localparam logic [AW-1:0] IDX_IRQ_STAT = 12'h018;
    localparam logic [AW-1:0] IDX_IRQ_MASK = 12'h019;

    // run command word bits
    localparam int RC_LOCK     = 1;
    localparam int RC_ABS_REQ  = 2;
    localparam int RC_PRESET   = 6;
    localparam int RC_LOAD     = 7;
    localparam int RC_W        = 16;

    // status word bits
    localparam int ST_HOMED    = 5;
    localparam int ST_LOCK     = 6;
    localparam int ST_ABS_DONE = 7;
    localparam int ST_LOAD     = 8;
    localparam int ST_PRESET   = 9;
    localparam int ST_DIR      = 10;

    // configuration bits
    localparam int CFG_INFINITE = 0;

    // interrupt status bits
    localparam int IRQ_SCAN    = 0;
    localparam int IRQ_HOMED   = 1;
    localparam int IRQ_ABS     = 2;
    localparam int IRQ_LOAD    = 3;
    localparam int IRQ_PRESET  = 4;

    localparam logic [DW-1:0] POS_RESET   = 32'h0000_0000;
    localparam logic [DW-1:0] RSTPOS_INIT = 32'h0000_0168;

endpackage

/* hw/asp_wrap.sv */
// one scan step of the calculated position, with infinite axis wrap
`timescale 1ns/1ps
module asp_wrap
#(
    parameter int W = 32
)
(
    input  wire logic [W-1:0] cur,
    input  wire logic [W-1:0] delta,
    input  wire logic         infinite,
    input  wire logic [W-1:0] reset_pos,
    output logic       [W-1:0] next_pos,
    output logic              wrap_up,
    output logic              wrap_dn
);

    //======================================================================
    // signed sum widened by one bit so the range test cannot overflow
    logic signed [W:0] sum;
    logic signed [W:0] bound;
    logic              wrap_on;
    logic              over;
    logic              under;

    assign sum     = $signed({cur[W-1], cur}) + $signed({delta[W-1], delta});
    assign bound   = $signed({1'b0, reset_pos});
    assign wrap_on = infinite && (reset_pos != '0);
    // one correction only: a per-scan move must stay below the bound
    assign over    = wrap_on && (sum >= bound);               // see RULE_12
    assign under   = wrap_on && (sum < 0);                    // see RULE_12
    assign wrap_up = over;
    assign wrap_dn = under;

    always_comb
    begin
        if (over)
            next_pos = W'(sum - bound);
        else if (under)
            next_pos = W'(sum + bound);
        else
            next_pos = W'(sum);
    end

endmodule

/* testbench/asp_axis_model.sv */
// far-side model: control scan source and servo event pulses
`timescale 1ns/1ps
module asp_axis_model
(
    input  wire logic        pclk,
    output logic             scan_tick,
    output logic [31:0]      scan_delta,
    output logic [2:0]       ends
);
    initial
    begin
        {scan_tick, scan_delta, ends} = '0;
    end
    //==========================================================
    // scan and event drivers
    // delta is only valid with the tick; garbage elsewhere
    task scan(input logic [31:0] d);
        @(posedge pclk);
        scan_tick <= 1'b1;
        scan_delta <= d;
        @(posedge pclk);
        scan_tick <= 1'b0;
        scan_delta <= ~d;
    endtask
    task pulse(input int k);
        @(posedge pclk);
        ends[k] <= 1'b1;
        @(posedge pclk);
        ends <= 3'h0;
    endtask
endmodule

/* testbench/asp_monitor_test.sv */
// self-checking bench of the axis status and position monitor
`timescale 1ns/1ps
module asp_monitor_test;
    import asp_pkg::*;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic          scan_tick, homing_busy, lock_engaged, enc_reverse;
    logic          drive_ref_stb, irq, er;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata, prdata, drive_ref_pos, scan_delta, rd;
    logic [2:0]    ends;
    int            failures, checks, cyc;
    asp_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scan_tick(scan_tick), .scan_delta(scan_delta),
        .homing_busy(homing_busy), .homing_end(ends[0]),
        .abs_read_end(ends[1]), .wrap_load_end(ends[2]),
        .lock_engaged(lock_engaged), .enc_reverse(enc_reverse),
        .drive_ref_pos(drive_ref_pos), .drive_ref_stb(drive_ref_stb),
        .irq(irq));
    asp_axis_model m (.pclk(pclk), .scan_tick(scan_tick),
        .scan_delta(scan_delta), .ends(ends));
    //==========================================================
    // clock, reset, timeout
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            end_sim();
        end
    end
    task end_sim;
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task rst;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    //==========================================================
    // bus and compare helpers
    task apb(input logic w, input logic [AW-1:0] i, input logic [DW-1:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= i << 2;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input logic [DW-1:0] s, input logic [DW-1:0] e);
        checks++;
        if (s !== e)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task rdchk(input logic [AW-1:0] i, input logic [DW-1:0] e);
        apb(1'b0, i, 32'h0);
        chk(rd, e);
    endtask
    task st;
        apb(1'b0, IDX_STATUS, 32'h0);
    endtask
    //==========================================================
    // scenarios
    task t_reset;
        rdchk(IDX_TARGET, 32'h0);
        rdchk(IDX_CALC, 32'h0);
        rdchk(IDX_REF, 32'h0);
        apb(1'b0, 12'h3ff, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, IDX_TARGET, 32'h5);
        chk(er, 1'b1);
        rdchk(IDX_TARGET, 32'h0);
    endtask
    task t_finite;
        m.scan(32'h5);
        #1 chk(drive_ref_stb, 1'b1);
        m.scan(32'hffff_fff9);
        rdchk(IDX_TARGET, 32'hffff_fffe);
        rdchk(IDX_REF, 32'hffff_fffe);
        rdchk(IDX_WIDE, 32'hffff_fffe);
        chk(drive_ref_pos, 32'hffff_fffe);
        m.scan(32'h7fff_ffff);
        m.scan(32'h5);
        rdchk(IDX_WIDE, 32'h8000_0002);
    endtask
    task t_lock;
        apb(1'b1, IDX_RUN_CMD, 32'h2);
        m.scan(32'h1);
        st();
        chk(rd[ST_LOCK], 1'b0);
        @(posedge pclk);
        lock_engaged <= 1'b1;
        m.scan(32'h3);
        #1 chk(drive_ref_stb, 1'b0);
        st();
        chk(rd[ST_LOCK], 1'b1);
        rdchk(IDX_CALC, 32'h8000_0006);
        rdchk(IDX_REF, 32'h8000_0003);
        chk(drive_ref_pos, 32'h8000_0003);
        apb(1'b1, IDX_RUN_CMD, 32'h0);
        lock_engaged <= 1'b0;
    endtask
    task t_infinite;
        rst();
        rdchk(IDX_RESET_PS, RSTPOS_INIT);
        apb(1'b1, IDX_CONFIG, 32'h1);
        m.scan(32'd350);
        m.scan(32'd20);
        rdchk(IDX_CALC, 32'd10);
        rdchk(IDX_TARGET, 32'd370);
        rdchk(IDX_WIDE, 32'd370);
        rdchk(IDX_TURNS, 32'h1);
        m.scan(32'hffff_fff1);
        rdchk(IDX_CALC, 32'd355);
        rdchk(IDX_REF, 32'd355);
        rdchk(IDX_TURNS, 32'h0);
    endtask
    task t_flags;
        @(posedge pclk);
        homing_busy <= 1'b1;
        m.pulse(0);
        m.scan(32'h0);
        st();
        chk(rd[ST_HOMED], 1'b0);
        homing_busy <= 1'b0;
        m.pulse(0);
        st();
        chk(rd[ST_HOMED], 1'b0);
        m.scan(32'h0);
        st();
        chk(rd[ST_HOMED], 1'b1);
        apb(1'b1, IDX_RUN_CMD, 32'h4);
        m.pulse(1);
        m.scan(32'h0);
        st();
        chk(rd[ST_ABS_DONE], 1'b1);
        apb(1'b1, IDX_RUN_CMD, 32'h0);
        m.scan(32'h0);
        st();
        chk(rd[ST_ABS_DONE], 1'b0);
        apb(1'b1, IDX_PRESET, 32'h7);
        apb(1'b1, IDX_RUN_CMD, 32'hc0);
        m.pulse(2);
        m.scan(32'h0);
        st();
        chk(rd[10:8], 3'b011);
        rdchk(IDX_TURNS, 32'h7);
        enc_reverse <= 1'b1;
        m.scan(32'h0);
        st();
        chk(rd[ST_DIR], 1'b1);
    endtask
    task t_irq;
        apb(1'b1, IDX_IRQ_MASK, 32'h1);
        m.scan(32'h0);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b0, IDX_IRQ_STAT, 32'h0);
        chk(rd[IRQ_SCAN], 1'b1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, IDX_IRQ_MASK, 32'h0);
        m.scan(32'h0);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {homing_busy, lock_engaged, enc_reverse} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_finite();
        t_lock();
        t_infinite();
        t_flags();
        t_irq();
        end_sim();
    end
endmodule
